// File: design/ufic_map.svh
// Offsets, field positions and timing constants of the frame index counter.
// Assumes inclusion by bare name from the design files.
`ifndef UFIC_MAP_SVH
`define UFIC_MAP_SVH
`define UFIC_FRAME_INDEX_OFFSET 8'h2c
`define UFIC_FRAME_INDEX_RESET  32'h00000000
`define UFIC_CNT_WIDTH          14
`define UFIC_SOF_LSB            3
`define UFIC_SOF_MSB            13
`define UFIC_IDX_LSB            3
`define UFIC_MICROFRAME_NS      125000
`define UFIC_CLK_PERIOD_NS      8
`define UFIC_MICROFRAME_CYCLES  (`UFIC_MICROFRAME_NS / `UFIC_CLK_PERIOD_NS)
`define UFIC_LSS_1024           2'h0
`define UFIC_LSS_512            2'h1
`define UFIC_LSS_256            2'h2
`define UFIC_IDX_MSB_1024       12
`define UFIC_IDX_MSB_512        11
`define UFIC_IDX_MSB_256        10
`endif

// File: design/ufic_pkg.sv
// Types shared by the frame index counter files.
// Assumes ufic_map.svh on the include path.
`include "ufic_map.svh"
package ufic_pkg;
	typedef logic [`UFIC_CNT_WIDTH-1:0] ufic_count_t;
	typedef logic [10:0]                ufic_sof_t;
	typedef logic [9:0]                 ufic_index_t;
	typedef logic [31:0]                ufic_word_t;
endpackage

// File: design/ufic_timebase.sv
// Microframe tick generator: one-cycle pulse at the end of each microframe.
// Assumes sys_clk at the rate behind UFIC_CLK_PERIOD_NS and a synchronised reset.
`timescale 1ns/1ps
`include "ufic_map.svh"
module ufic_timebase #(
	parameter int CYCLES = `UFIC_MICROFRAME_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic rstSync_n,
	input  wire logic running,
	output logic      tick
);
	logic [31:0] count;
	logic [31:0] next_count;
	logic        next_tick;

	always_comb begin
		next_count = count;
		next_tick  = 1'b0;
		// Clear phase to zero while stopped so the first microframe after run is full length
		if (!running) begin
			next_count = 32'h0;
		end else if (count == 32'(CYCLES - 1)) begin
			next_count = 32'h0;
			next_tick  = 1'b1;
		end else begin
			next_count = count + 32'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			count <= 32'h0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end
endmodule

// File: design/ufic_frame_index.sv
// Frame index counter of the enhanced host controller, with its register port.
// Assumes a simple register port: regAddr/regWrite/regWdata, regRead/regRdata.
// The run/stop and halted bits come from the command and status registers outside.
`timescale 1ns/1ps
`include "ufic_map.svh"
//
// Behaviour
// - Counter increments once per 125 us microframe while running.
// - 14-bit counter in bits 13:0, upper bits reserved, resets to zero.
// - Counter bits 13:3 form the start-of-frame frame number.
// - Counter bits N:3 index the periodic frame list.
// - List size select 00/01/10 gives N of 12/11/10; 11 reserved.
// - Each list entry is used for eight consecutive microframes.
// - Writes take effect only while the halted flag is set.
// - A written value appears in later start-of-frame frame numbers.
module ufic_frame_index #(
	parameter int MICROFRAME_CYCLES = `UFIC_MICROFRAME_CYCLES
) (
	input  wire logic               sys_clk,
	input  wire logic               reset_n,
	input  wire logic               run_stop_bit,
	input  wire logic               halted_flag,
	input  wire logic [1:0]         list_size_select,
	input  wire logic [7:0]         regAddr,
	input  wire logic               regWrite,
	input  wire logic               regRead,
	input  wire ufic_pkg::ufic_word_t regWdata,
	output ufic_pkg::ufic_word_t    regRdata,
	output ufic_pkg::ufic_sof_t     sofFrameNumber,
	output ufic_pkg::ufic_index_t   listIndex,
	output logic                    microframeTick
);
	import ufic_pkg::*;

	logic        rstMeta_n;
	logic        rstSync_n;
	logic        tick;
	ufic_count_t frame_index_counter;
	ufic_count_t next_frame_index_counter;
	ufic_word_t  next_regRdata;
	ufic_sof_t   next_sofFrameNumber;
	ufic_index_t next_listIndex;

	// Reset released through two flops
	// Keeps the release edge away from the clock edge of every counter flop
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_n <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_n <= 1'b1;
			rstSync_n <= rstMeta_n;
		end
	end

	ufic_timebase #(
		.CYCLES (MICROFRAME_CYCLES)
	) u_timebase (
		.sys_clk   (sys_clk),
		.rstSync_n (rstSync_n),
		.running   (run_stop_bit),
		.tick      (tick)
	);

	// index width from list size; reserved code treated as 1024
	function automatic ufic_index_t list_index_of(input ufic_count_t cnt, input logic [1:0] sel);
		ufic_index_t idx;
		idx = cnt[`UFIC_IDX_MSB_1024:`UFIC_IDX_LSB];
		case (sel)
			`UFIC_LSS_1024: idx = cnt[`UFIC_IDX_MSB_1024:`UFIC_IDX_LSB];
			`UFIC_LSS_512:  idx = {1'b0, cnt[`UFIC_IDX_MSB_512:`UFIC_IDX_LSB]};
			`UFIC_LSS_256:  idx = {2'b00, cnt[`UFIC_IDX_MSB_256:`UFIC_IDX_LSB]};
			default:        idx = cnt[`UFIC_IDX_MSB_1024:`UFIC_IDX_LSB];
		endcase
		return idx;
	endfunction

	// Address decode shared by write, read and the checks
	function automatic logic hits_frame_index(input logic [7:0] addr);
		return addr == `UFIC_FRAME_INDEX_OFFSET;
	endfunction

	always_comb begin
		next_frame_index_counter = frame_index_counter;
		if (regWrite && hits_frame_index(regAddr) && halted_flag) begin
			next_frame_index_counter = regWdata[`UFIC_CNT_WIDTH-1:0];
		end else if (tick) begin
			next_frame_index_counter = frame_index_counter + ufic_count_t'(1);
		end
		// frame number follows the stored counter
		next_sofFrameNumber = next_frame_index_counter[`UFIC_SOF_MSB:`UFIC_SOF_LSB];
		// low three bits excluded, so each entry repeats eight times
		next_listIndex = list_index_of(next_frame_index_counter, list_size_select);
		next_regRdata  = 32'h0;
		// reserved bits read as zero; unmapped reads return zero
		if (regRead && hits_frame_index(regAddr)) begin
			next_regRdata = ufic_word_t'(frame_index_counter);
		end
	end

	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			frame_index_counter <= `UFIC_CNT_WIDTH'(`UFIC_FRAME_INDEX_RESET);
			regRdata            <= `UFIC_FRAME_INDEX_RESET;
			sofFrameNumber      <= ufic_sof_t'(`UFIC_FRAME_INDEX_RESET >> `UFIC_SOF_LSB);
			listIndex           <= ufic_index_t'(`UFIC_FRAME_INDEX_RESET >> `UFIC_IDX_LSB);
			microframeTick      <= 1'b0;
		end else begin
			frame_index_counter <= next_frame_index_counter;
			regRdata            <= next_regRdata;
			sofFrameNumber      <= next_sofFrameNumber;
			listIndex           <= next_listIndex;
			microframeTick      <= tick;
		end
	end

	AST_WRITE_WHEN_HALTED: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(regWrite && hits_frame_index(regAddr) && halted_flag)
		|=> (frame_index_counter == $past(regWdata[`UFIC_CNT_WIDTH-1:0])))
		else $error("halted write not stored");

	AST_NO_WRITE_RUNNING: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(regWrite && !halted_flag && !tick)
		|=> $stable(frame_index_counter))
		else $error("write accepted while not halted");

	AST_SOF_AFTER_WRITE: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(regWrite && hits_frame_index(regAddr) && halted_flag)
		|=> (sofFrameNumber == $past(regWdata[`UFIC_SOF_MSB:`UFIC_SOF_LSB])))
		else $error("frame number ignores written value");

	AST_INCREMENT: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(tick && !regWrite)
		|=> (frame_index_counter == $past(frame_index_counter) + ufic_count_t'(1)))
		else $error("counter did not advance on microframe");

	AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(!tick && !regWrite)
		|=> $stable(frame_index_counter))
		else $error("counter moved without microframe");

	AST_NO_TICK_STOPPED: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		!run_stop_bit
		|=> !tick)
		else $error("microframe ended while stopped");

	// microframes well apart
	// Assumes a microframe of at least eight clocks, true of any real setting
	AST_TICK_SPACING: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		tick
		|=> (!tick) [*7])
		else $error("microframes too close together");

	AST_TICK_OUT: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(microframeTick && !$past(regWrite && hits_frame_index(regAddr) && halted_flag))
		|-> (frame_index_counter == $past(frame_index_counter) + ufic_count_t'(1)))
		else $error("tick pulse without counter step");

	AST_WRAP: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(tick && !regWrite && frame_index_counter == '1)
		|=> (frame_index_counter == '0))
		else $error("counter did not wrap");

	AST_SOF: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		sofFrameNumber == frame_index_counter[`UFIC_SOF_MSB:`UFIC_SOF_LSB])
		else $error("frame number mismatch");

	AST_INDEX_1024: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		($past(list_size_select) == `UFIC_LSS_1024)
		|-> (listIndex == frame_index_counter[`UFIC_IDX_MSB_1024:`UFIC_IDX_LSB]))
		else $error("1024 entry index wrong");

	AST_INDEX_RESERVED: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		!($past(list_size_select) inside {`UFIC_LSS_1024, `UFIC_LSS_512, `UFIC_LSS_256})
		|-> (listIndex == frame_index_counter[`UFIC_IDX_MSB_1024:`UFIC_IDX_LSB]))
		else $error("reserved size index wrong");

	AST_INDEX_256: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		($past(list_size_select) == `UFIC_LSS_256)
		|-> (listIndex == ufic_index_t'(frame_index_counter[`UFIC_IDX_MSB_256:`UFIC_IDX_LSB])))
		else $error("256 entry index wrong");

	AST_INDEX_512: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		($past(list_size_select) == `UFIC_LSS_512)
		|-> (listIndex == ufic_index_t'(frame_index_counter[`UFIC_IDX_MSB_512:`UFIC_IDX_LSB])))
		else $error("512 entry index wrong");

	AST_INDEX_REPEAT: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(tick && !regWrite && frame_index_counter[`UFIC_IDX_LSB-1:0] != '1 && $stable(list_size_select))
		|=> $stable(listIndex))
		else $error("list entry left early");

	AST_READBACK: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(regRead && hits_frame_index(regAddr))
		|=> (regRdata == ufic_word_t'($past(frame_index_counter))))
		else $error("read data wrong");

	AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		(regRdata >> `UFIC_CNT_WIDTH) == '0)
		else $error("reserved bits not zero");

	AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
		!(regRead && hits_frame_index(regAddr))
		|=> (regRdata == '0))
		else $error("read data without read");
endmodule

// File: dv/testbench.sv
// Self-checking bench for the frame index counter block.
// Assumes the design package and modules are compiled first.
`timescale 1ns/1ps
module testbench;
	import ufic_pkg::*;
	logic        sys_clk;
	logic        reset_n;
	logic        run_stop_bit;
	logic        halted_flag;
	logic [1:0]  list_size_select;
	logic [7:0]  regAddr;
	logic        regWrite;
	logic        regRead;
	ufic_word_t  regWdata;
	ufic_word_t  regRdata;
	ufic_sof_t   sofFrameNumber;
	ufic_index_t listIndex;
	logic        microframeTick;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cycles    = 0;
	int          gap;
	ufic_word_t  rd;
	ufic_index_t expIdx[4] = '{10'h3ff, 10'h1ff, 10'h0ff, 10'h3ff};

	// Short microframe keeps the run brief
	ufic_frame_index #(.MICROFRAME_CYCLES(8)) ufic_frame_index_i (
		.sys_clk         (sys_clk),
		.reset_n         (reset_n),
		.run_stop_bit    (run_stop_bit),
		.halted_flag     (halted_flag),
		.list_size_select(list_size_select),
		.regAddr         (regAddr),
		.regWrite        (regWrite),
		.regRead         (regRead),
		.regWdata        (regWdata),
		.regRdata        (regRdata),
		.sofFrameNumber  (sofFrameNumber),
		.listIndex       (listIndex),
		.microframeTick  (microframeTick)
	);

	task automatic print_verdict;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input ufic_word_t seen, input ufic_word_t exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input ufic_word_t d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		#1;
	endtask

	task automatic rdReg(input logic [7:0] a, output ufic_word_t d);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 3000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		reset_n = 1'b0;
		run_stop_bit = 1'b0;
		halted_flag = 1'b1;
		list_size_select = 2'h0;
		regAddr = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWdata = 32'h00000000;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rdReg(8'h2c, rd);
		check(rd, 32'h00000000, "reset value");
		wr(8'h2c, 32'h00000123);
		check(sofFrameNumber, 32'h24, "frame number after write");
		check(listIndex, 32'h24, "list index after write");
		@(posedge sys_clk) halted_flag <= 1'b0;
		wr(8'h2c, 32'h00000055);
		@(posedge sys_clk) halted_flag <= 1'b1;
		wr(8'h30, 32'h00000077);
		rdReg(8'h2c, rd);
		check(rd, 32'h00000123, "write while not halted");
		rdReg(8'h30, rd);
		check(rd, 32'h00000000, "unmapped read");
		wr(8'h2c, 32'h00003fff);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk) list_size_select <= 2'(i);
			repeat (2) @(posedge sys_clk);
			#1 check(listIndex, expIdx[i], "index width per list size");
		end
		@(posedge sys_clk) list_size_select <= 2'h0;
		wr(8'h2c, 32'h00003ffe);
		@(posedge sys_clk) halted_flag <= 1'b0;
		run_stop_bit <= 1'b1;
		for (int k = 1; k <= 10; k++) begin
			gap = 0;
			do begin
				@(posedge sys_clk);
				#1 gap++;
			end while (microframeTick !== 1'b1 && gap < 20);
			check(gap, (k > 1) ? 8 : 9, "microframe spacing");
			check(sofFrameNumber, ((32'h3ffe + k) & 32'h3fff) >> 3, "frame number");
			check(listIndex, ((32'h3ffe + k) & 32'h1fff) >> 3, "list index");
		end
		rdReg(8'h2c, rd);
		check(rd, 32'h00000008, "count after wrap");
		@(posedge sys_clk) run_stop_bit <= 1'b0;
		halted_flag <= 1'b1;
		wr(8'h2c, 32'h00000010);
		check(sofFrameNumber, 32'h2, "frame number after halted write");
		repeat (20) @(posedge sys_clk);
		rdReg(8'h2c, rd);
		check(rd, 32'h00000010, "count holds while stopped");
		print_verdict();
	end
endmodule
